// File: rtl/coag_pkg.sv
// package of constants and types for the cpu operand address generator
package coag_pkg;

	// ------------------------------------------------------------
	// address space
	// ------------------------------------------------------------
	localparam int          ADDR_W          = 20;
	localparam logic [3:0]  HIGH_SEG        = 4'hf;
	localparam logic [19:0] SHORT_BASE      = 20'hffe20;
	localparam logic [19:0] SHORT_LAST      = 20'hfff1f;
	localparam logic [7:0]  SHORT_WRAP_FROM = 8'h20;
	localparam logic [11:0] SHORT_HI_LOW    = 12'hffe;
	localparam logic [11:0] SHORT_HI_HIGH   = 12'hfff;
	localparam logic [11:0] SFR_HI          = 12'hfff;
	localparam logic [19:0] RAM_BASE_DEF    = 20'hfef00;
	localparam logic [19:0] RAM_LAST_DEF    = 20'hffedf;

	// ------------------------------------------------------------
	// stack frame sizes
	// ------------------------------------------------------------
	localparam logic [15:0] SP_FRAME4 = 16'h0004;
	localparam logic [15:0] SP_FRAME2 = 16'h0002;
	localparam logic [15:0] SP_ONE    = 16'h0001;
	localparam logic [2:0]  LAST_IDX4 = 3'h3;
	localparam logic [2:0]  LAST_IDX2 = 3'h1;

	// ------------------------------------------------------------
	// register pair indices and byte register indices
	// ------------------------------------------------------------
	localparam logic [1:0] PAIR_FIRST  = 2'h0;
	localparam logic [1:0] PAIR_SECOND = 2'h1;
	localparam logic [1:0] PAIR_THIRD  = 2'h2;
	localparam logic [1:0] PAIR_FOURTH = 2'h3;
	localparam logic [2:0] REG_X       = 3'h0;
	localparam logic [2:0] REG_A       = 3'h1;
	localparam logic [2:0] REG_C       = 3'h2;
	localparam logic [2:0] REG_B       = 3'h3;

	// ------------------------------------------------------------
	// operand address modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_IMPLIED,
		MODE_REG8,
		MODE_REG16,
		MODE_DIRECT,
		MODE_SHORT_BYTE,
		MODE_SHORT_WORD,
		MODE_SFR_BYTE,
		MODE_SFR_WORD,
		MODE_INDIRECT,
		MODE_BASED_PAIR,
		MODE_BASED_SP,
		MODE_BASED_BYTEREG,
		MODE_BASED_WORDREG,
		MODE_BASED_INDEXED
	} coag_mode_type;

	// ------------------------------------------------------------
	// stack sequences
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		STK_PUSH,
		STK_POP,
		STK_CALL,
		STK_RET,
		STK_INTR,
		STK_RETURN_FROM_INTERRUPT
	} coag_stack_op_type;

endpackage

// File: rtl/coag_stack_frame.sv
// stack frame sequencer: walks the byte slots of one stack operation
`timescale 1ns/1ps
`default_nettype none
module coag_stack_frame
	import coag_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// request
	input  wire logic        start,
	input  wire logic [2:0]  lastIdx,
	// slot walk
	output logic             busy,
	output logic [2:0]       slotIdx,
	output logic             slotValid,
	output logic             done
);

	logic [2:0] idx_r;
	logic [2:0] idx_nxt;
	logic [2:0] last_r;
	logic       busy_r;
	logic       busy_nxt;
	logic       done_r;
	wire  logic atLast = (idx_r == last_r);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// a new start is ignored while a frame is still walking
	assign busy_nxt = busy_r ? !atLast : start;
	assign idx_nxt  = busy_r ? (atLast ? 3'h0 : 3'(idx_r + 3'h1)) : 3'h0;

	// slot counter and frame length
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			idx_r  <= 3'h0;
			last_r <= 3'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			idx_r  <= idx_nxt;
			busy_r <= busy_nxt;
			done_r <= busy_r && atLast;
			if (!busy_r && start) begin
				last_r <= lastIdx;
			end
		end
	end

	assign busy      = busy_r;
	assign slotIdx   = idx_r;
	assign slotValid = busy_r;
	assign done      = done_r;

endmodule
`default_nettype wire

// File: rtl/coag_top.sv
// cpu operand address generator: data address forms and stack frames
// ------------------------------------------------------------
// ------------------------------------------------------------
// timing and limits
// ------------------------------------------------------------
// operand answer lands one cycle after opValid and holds until the next.
// register forms return a bank index; the core reads the bank itself.
// based sums wrap in sixteen bits, never carrying into the segment nibble.
// the based stack pointer form ignores the segment prefix.
// short direct and special register forms ignore the prefix as well.
// a stack op is taken only while stkBusy is low; a request while it is high is dropped.
// slot pulses come one per cycle once the op is taken; spNew follows the last.
// call frames pad their top byte with zero to keep a four-byte step.
// restores only place addresses; the core captures the returned bytes.
// the ram window is a parameter pair so a smaller part can shrink it.
// a stack slot outside the window is flagged, never corrected.
// the core must trap that flag: the bytes have already gone out.
`timescale 1ns/1ps
`default_nettype none
module coag_top
	import coag_pkg::*;
#(
	parameter logic [19:0] RAM_BASE = RAM_BASE_DEF,
	parameter logic [19:0] RAM_LAST = RAM_LAST_DEF
)(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// operand request from the core
	input  wire logic              opValid,
	input  wire coag_mode_type     opMode,
	input  wire logic              segPrefix,
	input  wire logic [2:0]        regSel,
	input  wire logic [1:0]        pairSel,
	input  wire logic [15:0]       immWord,
	input  wire logic [7:0]        immByte,
	input  wire logic              wordOffset,
	input  wire logic              useCReg,
	// register bank and segment
	input  wire logic [63:0]       bankRegs,
	input  wire logic [15:0]       stackPtr,
	input  wire logic [3:0]        extra_segment_reg,
	// stack request from the core
	input  wire logic              stkValid,
	input  wire coag_stack_op_type stkOp,
	input  wire logic [19:0]       pcValue,
	input  wire logic [7:0]        program_status_word,
	input  wire logic [15:0]       pushPair,
	// operand answer
	output logic                   addrValid,
	output logic [19:0]            operandAddr,
	output logic                   regOperand,
	output logic [2:0]             regIndex,
	output logic                   implicitMul,
	// stack bus and answer
	output logic                   stkBusy,
	output logic                   stkAccess,
	output logic                   stkWrite,
	output logic [19:0]            stkAddr,
	output logic [7:0]             stkWdata,
	output logic [15:0]            spNew,
	output logic                   spNewValid,
	output logic                   stkRangeErr
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// refuse an empty ram window
	if (RAM_LAST < RAM_BASE) begin : g_ramEmpty
		$error("coag_top: ram window is empty");
	end
	// stack slots always carry the top nibble, so the window must as well
	if ((RAM_BASE[19:16] != HIGH_SEG) || (RAM_LAST[19:16] != HIGH_SEG)) begin : g_ramSeg
		$error("coag_top: ram window outside the top region");
	end

	// byte register from bank, picked by a three-bit field
	function automatic logic [7:0] byteReg(input logic [63:0] bank, input logic [2:0] sel);
		byteReg = bank[{sel, 3'h0} +: 8];
	endfunction

	// pair from two neighbouring byte registers, low byte at even index
	function automatic logic [15:0] pairReg(input logic [63:0] bank, input logic [1:0] sel);
		pairReg = bank[{sel, 4'h0} +: 16];
	endfunction

	// upper nibble: segment register when prefixed, else the top region
	function automatic logic [3:0] segOf(input logic pre, input logic [3:0] seg);
		segOf = pre ? seg : HIGH_SEG;
	endfunction

	// ------------------------------------------------------------
	// operand address decode
	// ------------------------------------------------------------
	// bank pairs and segment nibble
	wire logic [3:0]  segHi    = segOf(segPrefix, extra_segment_reg);
	wire logic [15:0] pair2    = pairReg(bankRegs, PAIR_SECOND);
	wire logic [15:0] pair3    = pairReg(bankRegs, PAIR_THIRD);
	wire logic [15:0] pair4    = pairReg(bankRegs, PAIR_FOURTH);
	// index byte and based offset pickers
	wire logic [7:0]  idxByte  = useCReg ? byteReg(bankRegs, REG_C) : byteReg(bankRegs, REG_B);
	wire logic [15:0] offWord  = wordOffset ? immWord : {8'h00, immByte};
	// only the third or fourth pair may act as a pointer
	wire logic [15:0] ptrPair  = pairSel[0] ? pair4 : pair3;
	// sums stay 16 bits wide so a carry never leaks into the segment
	wire logic [15:0] sumPair  = 16'(ptrPair + {8'h00, immByte});
	wire logic [15:0] sumSp    = 16'(stackPtr + offWord);
	wire logic [15:0] sumBreg  = 16'(immWord + {8'h00, idxByte});
	wire logic [15:0] sumWreg  = 16'(immWord + pair2);
	wire logic [15:0] sumIdx   = 16'(pair4 + {8'h00, idxByte});
	// short direct: offsets 20h..ffh sit in page fe, 00h..1fh in page ff
	wire logic [11:0] shortHi  = (immByte >= SHORT_WRAP_FROM) ? SHORT_HI_LOW : SHORT_HI_HIGH;
	wire logic [19:0] shortAdr = {shortHi, immByte};
	wire logic [19:0] sfrAdr   = {SFR_HI, immByte};

	// ------------------------------------------------------------
	// mode select
	// ------------------------------------------------------------
	logic [19:0] addr_nxt;
	logic        isReg_nxt;
	logic [2:0]  regIdx_nxt;
	logic        isMul_nxt;

	// mode select; register forms return a bank index instead of an address
	always_comb begin
		addr_nxt   = 20'h00000;
		isReg_nxt  = 1'b0;
		regIdx_nxt = 3'h0;
		isMul_nxt  = 1'b0;
		case (opMode)
			MODE_IMPLIED: begin
				isMul_nxt  = 1'b1;
				isReg_nxt  = 1'b1;
				regIdx_nxt = REG_A;
			end
			MODE_REG8: begin
				isReg_nxt  = 1'b1;
				regIdx_nxt = regSel;
			end
			MODE_REG16: begin
				isReg_nxt  = 1'b1;
				regIdx_nxt = {pairSel, 1'b0};
			end
			MODE_DIRECT:        addr_nxt = {segHi, immWord};
			MODE_SHORT_BYTE:    addr_nxt = shortAdr;
			MODE_SHORT_WORD:    addr_nxt = {shortAdr[19:1], 1'b0};
			MODE_SFR_BYTE:      addr_nxt = sfrAdr;
			MODE_SFR_WORD:      addr_nxt = {sfrAdr[19:1], 1'b0};
			MODE_INDIRECT:      addr_nxt = {segHi, ptrPair};
			MODE_BASED_PAIR:    addr_nxt = {segHi, sumPair};
			// the stack lives in the top region, so no prefix here
			MODE_BASED_SP:      addr_nxt = {HIGH_SEG, sumSp};
			MODE_BASED_BYTEREG: addr_nxt = {segHi, sumBreg};
			MODE_BASED_WORDREG: addr_nxt = {segHi, sumWreg};
			MODE_BASED_INDEXED: addr_nxt = {segHi, sumIdx};
			default:            addr_nxt = 20'h00000;
		endcase
	end

	// ------------------------------------------------------------
	// operand answer register
	// ------------------------------------------------------------
	logic        addrValid_r;
	logic [19:0] operandAddr_r;
	logic        regOperand_r;
	logic [2:0]  regIndex_r;
	logic        implicitMul_r;

	// operand answer register, one cycle after the request
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addrValid_r   <= 1'b0;
			operandAddr_r <= 20'h00000;
			regOperand_r  <= 1'b0;
			regIndex_r    <= 3'h0;
			implicitMul_r <= 1'b0;
		end else begin
			addrValid_r <= opValid;
			if (opValid) begin
				operandAddr_r <= addr_nxt;
				regOperand_r  <= isReg_nxt;
				regIndex_r    <= regIdx_nxt;
				implicitMul_r <= isMul_nxt;
			end
		end
	end

	// outputs come straight from their flops
	assign addrValid   = addrValid_r;
	assign operandAddr = operandAddr_r;
	assign regOperand  = regOperand_r;
	assign regIndex    = regIndex_r;
	assign implicitMul = implicitMul_r;

	// ------------------------------------------------------------
	// stack sequencing
	// ------------------------------------------------------------
	coag_stack_op_type op_r;
	logic [15:0]       sp_r;
	logic [31:0]       frame_r;
	logic              seqBusy;
	logic [2:0]        seqIdx;
	logic              seqValid;
	logic              seqDone;

	// request decode: the incoming op picks frame contents and length
	wire logic accept    = stkValid && !seqBusy;
	wire logic reqIntr   = (stkOp == STK_INTR);
	wire logic reqCall   = (stkOp == STK_CALL);
	wire logic shortOp   = (stkOp == STK_PUSH) || (stkOp == STK_POP);
	// held op decode: steers direction and pointer step during the walk
	wire logic isWriteOp = (op_r == STK_PUSH) || (op_r == STK_CALL) || (op_r == STK_INTR);
	wire logic heldShort = (op_r == STK_PUSH) || (op_r == STK_POP);

	// ------------------------------------------------------------
	// stack frame contents
	// ------------------------------------------------------------
	// interrupt frame: status, pc[19:16], pc[15:8], pc[7:0] at sp-1..sp-4
	wire logic [31:0] intrFrame = {program_status_word, 4'h0, pcValue[19:16],
		pcValue[15:8], pcValue[7:0]};
	// call frame: pc low at sp-4 upward, top byte left zero
	wire logic [31:0] callFrame = {8'h00, 4'h0, pcValue[19:16],
		pcValue[15:8], pcValue[7:0]};
	wire logic [31:0] pushFrame = {pushPair[15:8], pushPair[7:0], 16'h0000};
	wire logic [31:0] frameSel = reqIntr ? intrFrame :
		reqCall ? callFrame : pushFrame;
	// frame bytes leave highest first, so slot 0 takes the top byte
	wire logic [1:0]  laneSel = 2'(LAST_IDX4 - seqIdx[1:0]);
	wire logic [7:0]  wrByte  = frame_r[{laneSel, 3'h0} +: 8];

	// ------------------------------------------------------------
	// stack slot addressing
	// ------------------------------------------------------------
	// bytes moved per op set the pointer step
	wire logic [15:0] frameLen = heldShort ? SP_FRAME2 : SP_FRAME4;
	// writes walk downward from sp-1; reads walk upward from sp
	wire logic [15:0] slotOff = 16'({13'h0000, seqIdx});
	wire logic [15:0] wrAdr16 = 16'(sp_r - SP_ONE - slotOff);
	wire logic [15:0] rdAdr16 = 16'(sp_r + slotOff);
	wire logic [15:0] curAdr16 = isWriteOp ? wrAdr16 : rdAdr16;
	wire logic [19:0] curAdr  = {HIGH_SEG, curAdr16};
	// pointer after the walk: down for saves, up for restores
	wire logic [15:0] spDone  = isWriteOp ? 16'(sp_r - frameLen) : 16'(sp_r + frameLen);
	// a slot outside the ram window marks the whole op
	wire logic        inRam   = (curAdr >= RAM_BASE) && (curAdr <= RAM_LAST);

	// ------------------------------------------------------------
	// slot sequencer
	// ------------------------------------------------------------
	coag_stack_frame u_frame (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.start     (accept),
		.lastIdx   (shortOp ? LAST_IDX2 : LAST_IDX4),
		.busy      (seqBusy),
		.slotIdx   (seqIdx),
		.slotValid (seqValid),
		.done      (seqDone)
	);

	// ------------------------------------------------------------
	// stack outputs
	// ------------------------------------------------------------
	logic        stkAccess_r;
	logic        stkWrite_r;
	logic [19:0] stkAddr_r;
	logic [7:0]  stkWdata_r;
	logic [15:0] spNew_r;
	logic        spNewValid_r;
	logic        stkRangeErr_r;

	// capture request, then register each byte slot onto the memory side
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			op_r          <= STK_PUSH;
			sp_r          <= 16'h0000;
			frame_r       <= 32'h00000000;
			stkAccess_r   <= 1'b0;
			stkWrite_r    <= 1'b0;
			stkAddr_r     <= 20'h00000;
			stkWdata_r    <= 8'h00;
			spNew_r       <= 16'h0000;
			spNewValid_r  <= 1'b0;
			stkRangeErr_r <= 1'b0;
		end else begin
			if (accept) begin
				op_r    <= stkOp;
				sp_r    <= stackPtr;
				frame_r <= frameSel;
			end
			stkAccess_r  <= seqValid;
			stkWrite_r   <= seqValid && isWriteOp;
			stkAddr_r    <= seqValid ? curAdr : 20'h00000;
			stkWdata_r   <= (seqValid && isWriteOp) ? wrByte : 8'h00;
			spNewValid_r <= seqDone;
			if (seqDone) begin
				spNew_r <= spDone;
			end
			// sticky until the next operation begins; set wins over clear
			// so an error in the last slot is never lost to a new request
			if (seqValid && !inRam) begin
				stkRangeErr_r <= 1'b1;
			end else if (accept) begin
				stkRangeErr_r <= 1'b0;
			end
		end
	end

	// stack side outputs, all registered
	assign stkBusy     = seqBusy;
	assign stkAccess   = stkAccess_r;
	assign stkWrite    = stkWrite_r;
	assign stkAddr     = stkAddr_r;
	assign stkWdata    = stkWdata_r;
	assign spNew       = spNew_r;
	assign spNewValid  = spNewValid_r;
	assign stkRangeErr = stkRangeErr_r;

endmodule
`default_nettype wire

// File: tb/coag_mem_model.sv
// behavioural internal ram seen by the stack bus
`timescale 1ns/1ps
`default_nettype none
module coag_mem_model (
	// stack bus
	input wire logic        clock,
	input wire logic        stkAccess,
	input wire logic        stkWrite,
	input wire logic [19:0] stkAddr,
	input wire logic [7:0]  stkWdata,
	// read data, toggles when not read so stale values never pass
	output logic [7:0]      rdData
);
	logic [7:0] store [20'hf0000:20'hfffff]; // stack slots always carry the top nibble
	initial rdData = 8'h00;
	// one byte per slot pulse
	always @(posedge clock) begin
		if (stkAccess && stkWrite)
			store[stkAddr] <= stkWdata;
		if (stkAccess && !stkWrite)
			rdData <= store[stkAddr];
		else
			rdData <= ~rdData;
	end
endmodule
`default_nettype wire

// File: tb/coag_props.sv
// concurrent checks on the operand address generator ports
`timescale 1ns/1ps
`default_nettype none
module coag_props
	import coag_pkg::*;
(
	// clock and reset
	input wire logic          clock,
	input wire logic          sys_rst,
	// operand request
	input wire logic          opValid,
	input wire coag_mode_type opMode,
	input wire logic          segPrefix,
	input wire logic [2:0]    regSel,
	input wire logic [15:0]   immWord,
	input wire logic [7:0]    immByte,
	input wire logic          useCReg,
	input wire logic [63:0]   bankRegs,
	input wire logic [3:0]    extra_segment_reg,
	// answers
	input wire logic          addrValid,
	input wire logic [19:0]   operandAddr,
	input wire logic          regOperand,
	input wire logic [2:0]    regIndex,
	input wire logic          implicitMul,
	input wire logic          stkAccess,
	input wire logic          stkWrite,
	input wire logic [19:0]   stkAddr,
	input wire logic [7:0]    stkWdata
);
	// ------------------------------------------------------------
	// single clock domain, reset masks every check
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// address and register forms, judged one cycle after the request
	property p_dir; opValid && opMode == MODE_DIRECT && !segPrefix
		|=> addrValid && operandAddr == {4'hf, $past(immWord)}; endproperty
	a_dir: assert property (p_dir) else $error("direct address wrong");
	property p_seg; opValid && opMode == MODE_DIRECT && segPrefix
		|=> operandAddr == {$past(extra_segment_reg), $past(immWord)}; endproperty
	a_seg: assert property (p_seg) else $error("segment nibble wrong");
	property p_sb; opValid && opMode == MODE_SHORT_BYTE
		|=> operandAddr inside {[SHORT_BASE:SHORT_LAST]}; endproperty
	a_sb: assert property (p_sb) else $error("short byte out of window");
	property p_sw; opValid && opMode == MODE_SHORT_WORD
		|=> !operandAddr[0] && operandAddr inside {[SHORT_BASE:SHORT_LAST]}; endproperty
	a_sw: assert property (p_sw) else $error("short word address wrong");
	property p_sf; opValid && opMode == MODE_SFR_BYTE
		|=> operandAddr == {12'hfff, $past(immByte)}; endproperty
	a_sf: assert property (p_sf) else $error("special reg address wrong");
	property p_sfw; opValid && opMode == MODE_SFR_WORD
		|=> operandAddr == {12'hfff, $past(immByte[7:1]), 1'b0}; endproperty
	a_sfw: assert property (p_sfw) else $error("special word not even");
	property p_imp; opValid && opMode == MODE_IMPLIED
		|=> implicitMul && regOperand && regIndex == 3'h1; endproperty
	a_imp: assert property (p_imp) else $error("implied operand wrong");
	property p_r8; opValid && opMode == MODE_REG8
		|=> regOperand && regIndex == $past(regSel); endproperty
	a_r8: assert property (p_r8) else $error("byte register select wrong");
	property p_bx; opValid && opMode == MODE_BASED_INDEXED && !segPrefix
		|=> operandAddr == {4'hf, $past(bankRegs[63:48]
		+ (useCReg ? {8'h00, bankRegs[23:16]} : {8'h00, bankRegs[31:24]}))}; endproperty
	a_bx: assert property (p_bx) else $error("based indexed sum wrong");
	// stack slots stay in the top region, reads drive no data
	property p_sa; stkAccess |-> stkAddr[19:16] == 4'hf
		&& (stkWrite || stkWdata == 8'h00); endproperty
	a_sa: assert property (p_sa) else $error("stack slot wrong");
endmodule
bind coag_top coag_props u_props (.clock, .sys_rst, .opValid, .opMode, .segPrefix,
	.regSel, .immWord, .immByte, .useCReg, .bankRegs, .extra_segment_reg, .addrValid,
	.operandAddr, .regOperand, .regIndex, .implicitMul, .stkAccess, .stkWrite,
	.stkAddr, .stkWdata);
`default_nettype wire

// File: tb/coag_top_test.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module coag_top_test
	import coag_pkg::*;
;
	logic clock = 0, sys_rst = 1, opValid = 0, segPrefix = 0, wordOffset = 0;
	logic useCReg = 0, stkValid = 0;
	coag_mode_type     opMode = MODE_IMPLIED;
	coag_stack_op_type stkOp  = STK_PUSH;
	logic [2:0]  regSel = 0, regIndex;
	logic [1:0]  pairSel = 0;
	logic [15:0] immWord = 0, stackPtr = 16'hfe20, pushPair = 0, spNew;
	logic [7:0]  immByte = 0, statWord = 0, stkWdata;
	logic [63:0] bankRegs = 64'hfffe_4321_8040_1100;
	logic [3:0]  segReg = 0;
	logic [19:0] pcValue = 0, operandAddr, stkAddr;
	logic addrValid, regOperand, implicitMul, stkBusy, stkAccess, stkWrite;
	logic spNewValid, stkRangeErr;
	int err_total = 0, cmp_count = 0;

	initial forever #4 clock = ~clock;

	coag_top uut (.clock, .sys_rst, .opValid, .opMode, .segPrefix, .regSel, .pairSel,
		.immWord, .immByte, .wordOffset, .useCReg, .bankRegs, .stackPtr,
		.extra_segment_reg(segReg), .stkValid, .stkOp, .pcValue,
		.program_status_word(statWord), .pushPair, .addrValid, .operandAddr,
		.regOperand, .regIndex, .implicitMul, .stkBusy, .stkAccess, .stkWrite,
		.stkAddr, .stkWdata, .spNew, .spNewValid, .stkRangeErr);
	coag_mem_model mem (.clock, .stkAccess, .stkWrite, .stkAddr, .stkWdata,
		.rdData());

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	task summarize;
		$display("mismatches %0d of %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [19:0] seen, input logic [19:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one request; addrValid stands for the single cycle after it
	task fire(input coag_mode_type m);
		opMode = m;
		opValid = 1;
		@(posedge clock); #1;
		chk(addrValid, 1);
		opValid = 0;
		@(posedge clock); #1;
	endtask
	task ad(input coag_mode_type m, input logic [19:0] exp);
		fire(m);
		chk(operandAddr, exp);
	endtask
	// stack op, bounded wait for the new pointer
	task stk(input coag_stack_op_type o, input logic [15:0] exp);
		int n;
		stkOp = o;
		stkValid = 1;
		@(posedge clock); #1 stkValid = 0;
		n = 0;
		while (spNewValid !== 1'b1 && n < 20) begin
			@(posedge clock); #1 n++;
		end
		if (n == 20) begin
			err_total++;
			summarize();
		end
		chk(spNew, exp);
		@(posedge clock); #1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task s_direct;
		immWord = 16'h1234;
		ad(MODE_DIRECT, 20'hf1234);
		segReg = 4'h3;
		segPrefix = 1;
		ad(MODE_DIRECT, 20'h31234);
		immByte = 8'h21;
		ad(MODE_SHORT_WORD, 20'hffe20);
		segPrefix = 0;
		immByte = 8'h20;
		ad(MODE_SHORT_BYTE, 20'hffe20);
		immByte = 8'h1f;
		ad(MODE_SHORT_BYTE, 20'hfff1f);
		immByte = 8'hff;
		ad(MODE_SFR_BYTE, 20'hfffff);
		ad(MODE_SFR_WORD, 20'hffffe);
	endtask
	task s_based;
		pairSel = 2'h2;
		ad(MODE_INDIRECT, 20'hf4321);
		pairSel = 2'h3;
		segPrefix = 1;
		segReg = 4'h2;
		ad(MODE_INDIRECT, 20'h2fffe);
		segPrefix = 0;
		immByte = 8'h05;
		ad(MODE_BASED_PAIR, 20'hf0003);
		immWord = 16'h0100;
		wordOffset = 1;
		ad(MODE_BASED_SP, 20'hfff20);
		immWord = 16'h1000;
		useCReg = 1;
		ad(MODE_BASED_BYTEREG, 20'hf1040);
		ad(MODE_BASED_INDEXED, 20'hf003e);
		useCReg = 0;
		ad(MODE_BASED_BYTEREG, 20'hf1080);
		ad(MODE_BASED_WORDREG, 20'hf9040);
		ad(MODE_BASED_INDEXED, 20'hf007e);
	endtask
	task s_reg;
		regSel = 3'h5;
		fire(MODE_REG8);
		chk(regIndex, 3'h5);
		chk(regOperand, 1);
		fire(MODE_REG16);
		chk(regIndex, 3'h6);
		fire(MODE_IMPLIED);
		chk(implicitMul, 1);
		fire(MODE_DIRECT);
		chk(implicitMul, 0);
	endtask
	// interrupt frame, call frame, push, and an out-of-ram pointer
	task s_stack;
		statWord = 8'ha5;
		pcValue = 20'habcde;
		stk(STK_INTR, 16'hfe1c);
		chk(mem.store[20'hffe1f], 8'ha5);
		chk(mem.store[20'hffe1e], 8'h0a);
		chk(mem.store[20'hffe1d], 8'hbc);
		chk(mem.store[20'hffe1c], 8'hde);
		stackPtr = 16'hfe1c;
		stk(STK_RETURN_FROM_INTERRUPT, 16'hfe20);
		stackPtr = 16'hfe10;
		pcValue = 20'h12345;
		stk(STK_CALL, 16'hfe0c);
		chk(mem.store[20'hffe0e], 8'h01);
		chk(mem.store[20'hffe0c], 8'h45);
		stk(STK_RET, 16'hfe14);
		stackPtr = 16'hfe00;
		pushPair = 16'hbeef;
		stk(STK_PUSH, 16'hfdfe);
		chk(mem.store[20'hffdff], 8'hbe);
		chk(stkRangeErr, 0);
		stk(STK_POP, 16'hfe02);
		stackPtr = 16'h0000;
		stk(STK_PUSH, 16'hfffe);
		chk(stkRangeErr, 1);
		stackPtr = 16'hfe20;
		stk(STK_POP, 16'hfe22);
		chk(stkRangeErr, 0);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		#1 sys_rst = 0;
		chk(stkBusy, 0);
		s_direct();
		s_based();
		s_reg();
		s_stack();
		summarize();
	end
endmodule
`default_nettype wire
